// >>> design/interval_timer_defs.svh
// Register offsets, field positions, reset values and timing counts of the interval timer.
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH

`define ADDR_CONTROL 4'h0
`define ADDR_COUNT_LOW 4'h1
`define ADDR_COUNT_HIGH 4'h2
`define ADDR_IRQ_STATUS 4'h3
`define ADDR_IRQ_CLEAR 4'h4
`define ADDR_IRQ_ENABLE 4'h5
`define ADDR_CORE_IRQ_CONTROL 4'h6

`define CTRL_RUN_BIT 0
`define CTRL_CLOCK_SELECT_BIT 1
`define CTRL_PRESCALE_LSB 4
`define CTRL_WRITE_MASK 8'h33
`define CTRL_RESET 8'h00
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF

`define IRQ_OVERFLOW_BIT 0
`define CORE_PERIPH_EN_BIT 6
`define CORE_GLOBAL_EN_BIT 7
`define CORE_WRITE_MASK 8'hC0

`define SYSTEM_CLOCK_HZ 8000000
`define INSTR_CLOCK_DIVIDE 4
`define CORE_CLOCK_HZ 10000000
`define TICK_CYCLES ((`CORE_CLOCK_HZ) / (`SYSTEM_CLOCK_HZ))

`endif

// >>> design/interval_timer_pkg.sv
// Types shared by the interval timer design and its bench.
package interval_timer_pkg;

   typedef struct packed {
      logic [1:0] spare_hi;
      logic [1:0] prescale;
      logic [1:0] spare_lo;
      logic clock_select;
      logic run;
   } control_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } bus_req_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DONE = 2'b01
   } bus_state_t;

endpackage

// >>> design/interval_timer.sv
// Sixteen bit interval timer with prescaler and overflow interrupt behind an Avalon-MM slave.
`include "interval_timer_defs.svh"

module interval_timer (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sleep_mode,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus front end.

   interval_timer_pkg::bus_req_t req;
   interval_timer_pkg::bus_state_t bus_state_reg;
   interval_timer_pkg::control_t control_reg;
   logic [15:0] count_reg;
   logic [2:0] prescale_reg;
   logic [1:0] instr_phase_reg;
   logic gate_reg;
   logic overflow_flag_reg;
   logic overflow_enable_reg;
   logic [7:0] core_irq_control_reg;
   logic sleep_meta_reg;
   logic sleep_sync_reg;
   logic wr_fire;
   logic rd_fire;
   logic lane0;
   logic [7:0] wbyte;
   logic wr_low;
   logic wr_high;
   logic source_tick;
   logic prescale_tick;
   logic [15:0] count_next;
   logic rollover;
   logic clear_overflow;
   logic [31:0] read_next;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  writedata: avs_writedata};

   // Each access is taken on its first cycle and completes on the second.
   // A write lands at the edge where the master sees waitrequest low, never earlier.
   assign wr_fire = req.write && bus_state_reg == interval_timer_pkg::BUS_DONE;
   assign rd_fire = req.read && bus_state_reg == interval_timer_pkg::BUS_IDLE;
   assign lane0 = avs_byteenable[0];
   assign wbyte = req.writedata[7:0];
   assign wr_low = wr_fire && lane0 && req.address == `ADDR_COUNT_LOW;
   assign wr_high = wr_fire && lane0 && req.address == `ADDR_COUNT_HIGH;
   assign clear_overflow = wr_fire && lane0 && req.address == `ADDR_IRQ_CLEAR
                           && wbyte[`IRQ_OVERFLOW_BIT];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_reg <= interval_timer_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         unique case (bus_state_reg)
            interval_timer_pkg::BUS_IDLE: begin
               if (req.read || req.write) begin
                  bus_state_reg <= interval_timer_pkg::BUS_DONE;
                  avs_waitrequest <= 1'b0;
               end
            end
            interval_timer_pkg::BUS_DONE: begin
               bus_state_reg <= interval_timer_pkg::BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state_reg <= interval_timer_pkg::BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control and interrupt registers.

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         control_reg <= `CTRL_RESET;
      end else if (wr_fire && lane0 && req.address == `ADDR_CONTROL) begin
         control_reg <= wbyte & `CTRL_WRITE_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_enable_reg <= 1'b0;
      end else if (wr_fire && lane0 && req.address == `ADDR_IRQ_ENABLE) begin
         overflow_enable_reg <= wbyte[`IRQ_OVERFLOW_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_irq_control_reg <= 8'h00;
      end else if (wr_fire && lane0 && req.address == `ADDR_CORE_IRQ_CONTROL) begin
         core_irq_control_reg <= wbyte & `CORE_WRITE_MASK;
      end
   end

   // Sleep arrives from the power manager's domain, so it is synchronised first.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_meta_reg <= 1'b0;
         sleep_sync_reg <= 1'b0;
      end else begin
         sleep_meta_reg <= sleep_mode;
         sleep_sync_reg <= sleep_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock sources and prescaler.

   // Gate flop follows the run bit and is cleared while stopped.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_reg <= 1'b0;
      end else begin
         gate_reg <= control_reg.run;
      end
   end

   // Each core clock stands for one system clock; every fourth is an instruction clock.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_phase_reg <= 2'h0;
      end else if (!sleep_sync_reg) begin
         instr_phase_reg <= instr_phase_reg + 2'h1;
      end
   end

   assign source_tick = !sleep_sync_reg && gate_reg && control_reg.run
                        && (control_reg.clock_select || instr_phase_reg == 2'h3);

   function automatic logic [2:0] prescale_limit(input logic [1:0] sel);
      prescale_limit = 3'((4'h1 << sel) - 4'h1);
   endfunction

   assign prescale_tick = source_tick
                          && prescale_reg == prescale_limit(control_reg.prescale);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_reg <= 3'h0;
      end else if (wr_low || wr_high) begin
         prescale_reg <= 3'h0;
      end else if (prescale_tick) begin
         prescale_reg <= 3'h0;
      end else if (source_tick) begin
         prescale_reg <= prescale_reg + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter and overflow.

   // With the system clock at 1:1 the count moves on every core cycle, four per instruction.
   assign count_next = count_reg + 16'h0001;
   assign rollover = prescale_tick && count_reg == `COUNT_MAX;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= `COUNT_RESET;
      end else if (wr_low) begin
         count_reg <= {count_reg[15:8], wbyte};
      end else if (wr_high) begin
         count_reg <= {wbyte, count_reg[7:0]};
      end else if (prescale_tick) begin
         count_reg <= count_next;
      end
   end

   // A rollover in the same cycle as a clear leaves the flag set.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag_reg <= 1'b0;
      end else if (rollover) begin
         overflow_flag_reg <= 1'b1;
      end else if (clear_overflow) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= overflow_flag_reg && overflow_enable_reg && control_reg.run
                && core_irq_control_reg[`CORE_PERIPH_EN_BIT]
                && core_irq_control_reg[`CORE_GLOBAL_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   always_comb begin
      read_next = 32'h0000_0000;
      unique case (req.address)
         `ADDR_CONTROL: read_next[7:0] = control_reg;
         `ADDR_COUNT_LOW: read_next[7:0] = count_reg[7:0];
         `ADDR_COUNT_HIGH: read_next[7:0] = count_reg[15:8];
         `ADDR_IRQ_STATUS: read_next[`IRQ_OVERFLOW_BIT] = overflow_flag_reg;
         `ADDR_IRQ_ENABLE: read_next[`IRQ_OVERFLOW_BIT] = overflow_enable_reg;
         `ADDR_CORE_IRQ_CONTROL: read_next[7:0] = core_irq_control_reg;
         default: read_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_fire) begin
         avs_readdata <= read_next;
      end
   end

endmodule

// >>> bench/interval_timer_properties.sv
// Port checker of the interval timer, bound to its top module.
`include "interval_timer_defs.svh"
module interval_timer_properties (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sleep_mode,
   input wire logic irq
);
   logic wr_ok;
   assign wr_ok = avs_write && avs_waitrequest && avs_byteenable[0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   ////////////////////////////////////////
   a_bus_answer: assert property (s_take |=> s_answer)
      else $error("request not answered in one cycle");
   a_idle_hold: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("waitrequest low without request");
   a_rdata_cause: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
      else $error("read data changed without read");
   a_spare_zero: assert property (avs_read && avs_waitrequest && avs_address == `ADDR_CONTROL
      |=> (avs_readdata & ~32'h00000033) == 32'h00000000)
      else $error("spare control bits read nonzero");
   a_irq_run: assert property (wr_ok && avs_address == `ADDR_CONTROL && !avs_writedata[0]
      |-> ##[1:3] !irq)
      else $error("interrupt stays with timer stopped");
   a_irq_global: assert property (wr_ok && avs_address == `ADDR_CORE_IRQ_CONTROL
      && !avs_writedata[7] |-> ##[1:3] !irq)
      else $error("interrupt stays with global enable off");
   a_irq_enable: assert property (wr_ok && avs_address == `ADDR_IRQ_ENABLE && !avs_writedata[0]
      |-> ##[1:3] !irq)
      else $error("interrupt stays with overflow enable off");
endmodule

bind interval_timer interval_timer_properties i_props (.core_clk, .rst_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .sleep_mode, .irq);

// >>> bench/interval_timer_tb.sv
// Self-checking bench of the interval timer.
`include "interval_timer_defs.svh"
module interval_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   interval_timer_pkg::bus_req_t req = '0;
   logic [3:0] avs_byteenable = 4'h1;
   logic sleep_mode = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic [7:0] rd_val;
   logic [7:0] first;
   int mismatches = 0;
   int checks = 0;
   always #50 core_clk = ~core_clk;
   interval_timer i_dut (.core_clk, .rst_n, .avs_address(req.address), .avs_read(req.read),
      .avs_write(req.write), .avs_writedata(req.writedata), .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .sleep_mode, .irq);
   ////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus access; an idle edge first keeps back-to-back calls apart.
   task automatic access(input logic [3:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      req <= '{address: a, read: !w, write: w, writedata: {24'h000000, d}};
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) mismatches++;
      rd_val = avs_readdata[7:0];
      req <= '0;
   endtask
   // Two low byte reads exactly k cycles apart.
   task automatic delta(input int k, input logic [7:0] exp);
      access(`ADDR_COUNT_LOW, 1'b0, 8'h00);
      first = rd_val;
      repeat (k - 3) @(posedge core_clk);
      access(`ADDR_COUNT_LOW, 1'b0, 8'h00);
      check(rd_val - first, exp);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      access(`ADDR_CONTROL, 1'b1, 8'hFF);
      access(`ADDR_CONTROL, 1'b0, 8'h00);
      check(rd_val, 8'h33);
      avs_byteenable <= 4'h0;
      access(`ADDR_CONTROL, 1'b1, 8'h00);
      avs_byteenable <= 4'h1;
      access(`ADDR_CONTROL, 1'b0, 8'h00);
      check(rd_val, 8'h33);
      access(4'hF, 1'b0, 8'h00);
      check(rd_val, 8'h00);
      $display("control test done");
      for (int m = 0; m < 8; m++) begin
         access(`ADDR_CONTROL, 1'b1, {2'b00, m[1:0], 2'b00, m[2], 1'b1});
         access(`ADDR_COUNT_LOW, 1'b1, 8'h00);
         delta(64, m[2] ? 8'h40 >> m[1:0] : 8'h10 >> m[1:0]);
      end
      $display("rate test done");
      sleep_mode <= 1'b1;
      repeat (4) @(posedge core_clk);
      delta(64, 8'h00);
      sleep_mode <= 1'b0;
      access(`ADDR_CONTROL, 1'b1, 8'h02);
      delta(64, 8'h00);
      $display("freeze test done");
      access(`ADDR_COUNT_HIGH, 1'b1, 8'hFF);
      access(`ADDR_COUNT_LOW, 1'b1, 8'hF0);
      access(`ADDR_COUNT_HIGH, 1'b0, 8'h00);
      check(rd_val, 8'hFF);
      access(`ADDR_COUNT_LOW, 1'b0, 8'h00);
      check(rd_val, 8'hF0);
      access(`ADDR_IRQ_CLEAR, 1'b1, 8'h01);
      access(`ADDR_IRQ_ENABLE, 1'b1, 8'h01);
      access(`ADDR_CORE_IRQ_CONTROL, 1'b1, 8'hC0);
      check({7'h00, irq}, 8'h00);
      access(`ADDR_CONTROL, 1'b1, 8'h03);
      repeat (40) @(posedge core_clk);
      access(`ADDR_IRQ_STATUS, 1'b0, 8'h00);
      check(rd_val, 8'h01);
      check({7'h00, irq}, 8'h01);
      access(`ADDR_COUNT_HIGH, 1'b0, 8'h00);
      check(rd_val, 8'h00);
      access(`ADDR_CONTROL, 1'b1, 8'h02);
      repeat (4) @(posedge core_clk);
      check({7'h00, irq}, 8'h00);
      access(`ADDR_CONTROL, 1'b1, 8'h03);
      repeat (4) @(posedge core_clk);
      check({7'h00, irq}, 8'h01);
      access(`ADDR_CORE_IRQ_CONTROL, 1'b1, 8'h40);
      repeat (3) @(posedge core_clk);
      check({7'h00, irq}, 8'h00);
      access(`ADDR_IRQ_ENABLE, 1'b1, 8'h00);
      access(`ADDR_IRQ_CLEAR, 1'b1, 8'h01);
      access(`ADDR_IRQ_STATUS, 1'b0, 8'h00);
      check(rd_val, 8'h00);
      $display("overflow test done");
      close_out();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      close_out();
   end
endmodule
